// File: logic/cbr_pkg.sv
// Package of constants, selectors and carriers for the banked CPU register file
package cbr_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int WORD_W = 16;       // Data, address, base and stack registers
    localparam int WIDE_W = 20;       // Program counter and vector table base
    localparam int BYTE_W = 8;        // Byte half of the first two data registers
    localparam int PAIR_W = 32;       // Combined register pairs
    localparam int SEL_W = 4;         // Register selector width
    localparam int NUM_BANKS = 2;     // Banked copies
    localparam int BANKED_REGS = 7;   // Registers per bank
    localparam int BANK_ADDR_W = 4;   // Address into the banked store
    localparam int NUM_ARCH_REGS = 13; // Architectural registers in total

    // ------------------------------------------------------------
    // Flag word bit positions
    // ------------------------------------------------------------
    localparam int FLAG_BANK_BIT = 4;  // Register bank select
    localparam int FLAG_STACK_BIT = 7; // Stack pointer select

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
    localparam logic [WIDE_W-1:0] WIDE_RST = 20'h00000;
    localparam logic [WORD_W-1:0] FLAGS_RST = 16'h0000;

    // ------------------------------------------------------------
    // Register selectors (banked ones first, index equals slot)
    // ------------------------------------------------------------
    typedef enum logic [SEL_W-1:0] {
        SEL_DATA_ZERO   = 4'h0,
        SEL_DATA_ONE    = 4'h1,
        SEL_DATA_TWO    = 4'h2,
        SEL_DATA_THREE  = 4'h3,
        SEL_ADDR_ZERO   = 4'h4,
        SEL_ADDR_ONE    = 4'h5,
        SEL_FRAME_BASE  = 4'h6,
        SEL_STATIC_BASE = 4'h7,
        SEL_STACK       = 4'h8,
        SEL_USER_STACK  = 4'h9,
        SEL_INTR_STACK  = 4'hA,
        SEL_FLAGS       = 4'hB
    } cbr_sel_t;

    // Write sizes
    typedef enum logic [1:0] {
        SIZE_WORD = 2'h0,  // Full 16-bit register
        SIZE_LOW  = 2'h1,  // Low byte only
        SIZE_HIGH = 2'h2,  // High byte only
        SIZE_PAIR = 2'h3   // 32-bit pair
    } cbr_size_t;

    // Write request carrier
    typedef struct packed {
        logic en;                 // Write strobe
        cbr_sel_t sel;            // Target register
        cbr_size_t size;          // Width of the write
        logic [PAIR_W-1:0] data;  // Data, low word in bits 15:0
    } cbr_wr_t;

    // Wide register write carrier
    typedef struct packed {
        logic en;                 // Write strobe
        logic [WIDE_W-1:0] data;  // New value
    } cbr_wide_wr_t;

endpackage : cbr_pkg

// File: logic/cbr_bank_mem.sv
// Two-bank store for the banked registers, with registered combined read ports
module cbr_bank_mem (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Write port
    input wire logic wr_en,
    input wire logic [cbr_pkg::BANK_ADDR_W-1:0] wr_addr,
    input wire logic [cbr_pkg::WORD_W-1:0] wr_data,
    input wire logic [cbr_pkg::WORD_W-1:0] wr_mask,
    // Second write port for the upper word of a pair
    input wire logic wr2_en,
    input wire logic [cbr_pkg::BANK_ADDR_W-1:0] wr2_addr,
    input wire logic [cbr_pkg::WORD_W-1:0] wr2_data,
    // Read ports
    input wire logic [cbr_pkg::BANK_ADDR_W-1:0] rd_addr_a,
    input wire logic [cbr_pkg::BANK_ADDR_W-1:0] rd_addr_b,
    output logic [cbr_pkg::WORD_W-1:0] rd_data_a,
    output logic [cbr_pkg::WORD_W-1:0] rd_data_b
);

    localparam int DEPTH = 2 ** cbr_pkg::BANK_ADDR_W;

    // Storage words, bank in the top address bit
    logic [cbr_pkg::WORD_W-1:0] mem [DEPTH];

    // Writes keep unmasked bits so a byte write leaves its other half alone
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= cbr_pkg::WORD_RST;
            end
        end else begin
            if (wr_en) begin
                mem[wr_addr] <= (mem[wr_addr] & ~wr_mask) | (wr_data & wr_mask);
            end
            if (wr2_en) begin
                mem[wr2_addr] <= wr2_data;
            end
        end
    end

    // Registered read data
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_data_a <= cbr_pkg::WORD_RST;
            rd_data_b <= cbr_pkg::WORD_RST;
        end else begin
            rd_data_a <= mem[rd_addr_a];
            rd_data_b <= mem[rd_addr_b];
        end
    end

endmodule // cbr_bank_mem

// File: logic/cbr_register_file.sv
// Banked CPU register set: data, address, base, stack, program counter, vector base
// Overview of operation
// - Thirteen registers, seven duplicated in two banks
// - Four 16-bit data registers, read and write
// - First two data registers split into bytes
// - Data pairs form 32-bit operands, upper higher
// - Address registers act as data and bases
// - Address pair forms 32 bits, one upper
// - Frame base 16 bits, base for addressing
// - Program counter 20 bits wide
// - Vector table base 20 bits wide
// - Separate 16-bit user and interrupt stacks
// - Flag bit 7 picks active stack
// - Static base 16 bits, base for addressing
// - Flag bit 4 selects register bank
// - Clear selects interrupt stack, set user
// - Interrupt entry, hardware or software 0 to 31, clears stack select flag
module cbr_register_file (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Instruction boundary and interrupt entry
    input wire logic instr_end,
    input wire logic hw_int_ack,
    input wire logic sw_int_exec,
    input wire logic [5:0] sw_int_num,
    // Register write port
    input wire cbr_pkg::cbr_wr_t wr_req,
    // Program counter and vector base writes
    input wire cbr_pkg::cbr_wide_wr_t pc_wr,
    input wire cbr_pkg::cbr_wide_wr_t vtb_wr,
    // Read selectors
    input wire cbr_pkg::cbr_sel_t rd_sel_a,
    input wire cbr_pkg::cbr_sel_t rd_sel_b,
    input wire logic rd_pair_a,
    // Read data (one cycle after selection)
    output logic [cbr_pkg::PAIR_W-1:0] rd_data_a,
    output logic [cbr_pkg::WORD_W-1:0] rd_data_b,
    // Addressing bases and wide registers
    output logic [cbr_pkg::WORD_W-1:0] frame_base,
    output logic [cbr_pkg::WORD_W-1:0] static_base,
    output logic [cbr_pkg::WORD_W-1:0] stack_pointer,
    output logic [cbr_pkg::WIDE_W-1:0] program_counter,
    output logic [cbr_pkg::WIDE_W-1:0] vector_table_base,
    output logic [cbr_pkg::WORD_W-1:0] flags_word,
    // Active selections
    output logic bank_active,
    output logic user_stack_active
);

    // ------------------------------------------------------------
    // Constants and helpers
    // ------------------------------------------------------------
    localparam logic [5:0] SW_INT_LAST = 6'h1F;            // Last number that clears the flag
    localparam logic [cbr_pkg::WORD_W-1:0] MASK_ALL = 16'hFFFF;
    localparam logic [cbr_pkg::WORD_W-1:0] MASK_LOW = 16'h00FF;
    localparam logic [cbr_pkg::WORD_W-1:0] MASK_HIGH = 16'hFF00;

    // Banked slot address from bank and selector
    function automatic logic [cbr_pkg::BANK_ADDR_W-1:0] slot(input logic bank,
                                                               input cbr_pkg::cbr_sel_t s);
        slot = {bank, s[2:0]};
    endfunction

    // Whether a selector names a banked register
    function automatic logic is_banked(input cbr_pkg::cbr_sel_t s);
        is_banked = (s < cbr_pkg::SEL_STATIC_BASE);
    endfunction

    // Upper partner of a pairable register, or the selector itself
    function automatic cbr_pkg::cbr_sel_t partner(input cbr_pkg::cbr_sel_t s);
        if (s == cbr_pkg::SEL_DATA_ZERO) begin
            partner = cbr_pkg::SEL_DATA_TWO;
        end else if (s == cbr_pkg::SEL_DATA_ONE) begin
            partner = cbr_pkg::SEL_DATA_THREE;
        end else if (s == cbr_pkg::SEL_ADDR_ZERO) begin
            partner = cbr_pkg::SEL_ADDR_ONE;
        end else begin
            partner = s;
        end
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [cbr_pkg::WORD_W-1:0] user_stack_pointer;      // User stack
    logic [cbr_pkg::WORD_W-1:0] interrupt_stack_pointer; // Interrupt stack
    logic [cbr_pkg::WORD_W-1:0] flags_reg;               // Flag word as written
    logic bank_sel;                                      // Bank in force for accesses
    logic stack_sel;                                     // Stack in force for accesses
    logic next_stack_flag;                               // Flag word bit after this cycle
    logic int_entry;                                     // Interrupt entry event
    logic [cbr_pkg::WORD_W-1:0] bank_rd_a;
    logic [cbr_pkg::WORD_W-1:0] bank_rd_b;
    logic [cbr_pkg::WORD_W-1:0] fb_copy [cbr_pkg::NUM_BANKS]; // Frame base, one per bank
    logic [cbr_pkg::WORD_W-1:0] wr_mask;
    logic bank_wr_en;
    logic pair_wr_en;
    logic a_banked;
    logic b_banked;
    logic a_pair;
    cbr_pkg::cbr_sel_t a_sel_q;
    cbr_pkg::cbr_sel_t b_sel_q;
    logic [cbr_pkg::WORD_W-1:0] side_a;
    logic [cbr_pkg::WORD_W-1:0] side_b;

    // ------------------------------------------------------------
    // Banked store
    // ------------------------------------------------------------
    // Byte writes reach every banked register; unbanked ones always take the whole word
    always_comb begin
        wr_mask = MASK_ALL;
        if (wr_req.size == cbr_pkg::SIZE_LOW) begin
            wr_mask = MASK_LOW;
        end else if (wr_req.size == cbr_pkg::SIZE_HIGH) begin
            wr_mask = MASK_HIGH;
        end
    end

    assign bank_wr_en = wr_req.en && is_banked(wr_req.sel);
    assign pair_wr_en = bank_wr_en && (wr_req.size == cbr_pkg::SIZE_PAIR)
                        && (partner(wr_req.sel) != wr_req.sel);

    // Two-bank store holding seven registers per bank
    cbr_bank_mem u_bank_mem (
        .ref_clk(ref_clk),
        .rst(rst),
        .wr_en(bank_wr_en),
        .wr_addr(slot(bank_sel, wr_req.sel)),
        .wr_data(wr_req.data[cbr_pkg::WORD_W-1:0]),
        .wr_mask(wr_mask),
        .wr2_en(pair_wr_en),
        .wr2_addr(slot(bank_sel, partner(wr_req.sel))),
        .wr2_data(wr_req.data[cbr_pkg::PAIR_W-1:cbr_pkg::WORD_W]),
        .rd_addr_a(slot(bank_sel, rd_sel_a)),
        .rd_addr_b(rd_pair_a ? slot(bank_sel, partner(rd_sel_a)) : slot(bank_sel, rd_sel_b)),
        .rd_data_a(bank_rd_a),
        .rd_data_b(bank_rd_b)
    );

    // ------------------------------------------------------------
    // Flag word and selections
    // ------------------------------------------------------------
    assign int_entry = hw_int_ack || (sw_int_exec && (sw_int_num <= SW_INT_LAST));

    // Stack flag: interrupt entry clears, and wins over a same-cycle write
    always_comb begin
        next_stack_flag = flags_reg[cbr_pkg::FLAG_STACK_BIT];
        if (int_entry) begin
            next_stack_flag = 1'b0;
        end else if (wr_req.en && wr_req.sel == cbr_pkg::SEL_FLAGS) begin
            next_stack_flag = wr_req.data[cbr_pkg::FLAG_STACK_BIT];
        end
    end

    // Flag word register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flags_reg <= cbr_pkg::FLAGS_RST;
        end else begin
            if (wr_req.en && wr_req.sel == cbr_pkg::SEL_FLAGS) begin
                flags_reg <= wr_req.data[cbr_pkg::WORD_W-1:0];
            end
            flags_reg[cbr_pkg::FLAG_STACK_BIT] <= next_stack_flag;
        end
    end

    // Selections follow the flag word at instruction boundaries and on interrupt entry
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bank_sel <= 1'b0;
            stack_sel <= 1'b0;
        end else if (instr_end || int_entry) begin
            bank_sel <= flags_reg[cbr_pkg::FLAG_BANK_BIT];
            stack_sel <= next_stack_flag;
        end
    end

    // ------------------------------------------------------------
    // Stack pointers
    // ------------------------------------------------------------
    // Writes go to the active stack or to a named one; the other is kept
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            user_stack_pointer <= cbr_pkg::WORD_RST;
            interrupt_stack_pointer <= cbr_pkg::WORD_RST;
        end else if (wr_req.en) begin
            if (wr_req.sel == cbr_pkg::SEL_USER_STACK
                || (wr_req.sel == cbr_pkg::SEL_STACK && stack_sel)) begin
                user_stack_pointer <= wr_req.data[cbr_pkg::WORD_W-1:0];
            end else if (wr_req.sel == cbr_pkg::SEL_INTR_STACK
                         || (wr_req.sel == cbr_pkg::SEL_STACK && !stack_sel)) begin
                interrupt_stack_pointer <= wr_req.data[cbr_pkg::WORD_W-1:0];
            end
        end
    end

    // Active stack pointer
    assign stack_pointer = stack_sel ? user_stack_pointer : interrupt_stack_pointer;

    // ------------------------------------------------------------
    // Static base and wide registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            static_base <= cbr_pkg::WORD_RST;
        end else if (wr_req.en && wr_req.sel == cbr_pkg::SEL_STATIC_BASE) begin
            static_base <= wr_req.data[cbr_pkg::WORD_W-1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            program_counter <= cbr_pkg::WIDE_RST;
        end else if (pc_wr.en) begin
            program_counter <= pc_wr.data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            vector_table_base <= cbr_pkg::WIDE_RST;
        end else if (vtb_wr.en) begin
            vector_table_base <= vtb_wr.data;
        end
    end

    // ------------------------------------------------------------
    // Frame base copies
    // ------------------------------------------------------------
    // One copy per bank beside the store, so a bank switch shows at once
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fb_copy[0] <= cbr_pkg::WORD_RST;
            fb_copy[1] <= cbr_pkg::WORD_RST;
        end else if (bank_wr_en && wr_req.sel == cbr_pkg::SEL_FRAME_BASE) begin
            // Same mask as the store, so both copies always agree
            fb_copy[bank_sel] <= (fb_copy[bank_sel] & ~wr_mask)
                                 | (wr_req.data[cbr_pkg::WORD_W-1:0] & wr_mask);
        end
    end

    // Active copy; the other bank's copy is left untouched
    assign frame_base = fb_copy[bank_sel];

    // ------------------------------------------------------------
    // Read ports
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            a_sel_q <= cbr_pkg::SEL_DATA_ZERO;
            b_sel_q <= cbr_pkg::SEL_DATA_ZERO;
            a_pair <= 1'b0;
            side_a <= cbr_pkg::WORD_RST;
            side_b <= cbr_pkg::WORD_RST;
        end else begin
            a_sel_q <= rd_sel_a;
            b_sel_q <= rd_sel_b;
            a_pair <= rd_pair_a && (partner(rd_sel_a) != rd_sel_a);
            side_a <= unbanked(rd_sel_a);
            side_b <= unbanked(rd_sel_b);
        end
    end

    // Unbanked register value by selector
    function automatic logic [cbr_pkg::WORD_W-1:0] unbanked(input cbr_pkg::cbr_sel_t s);
        case (s)
            cbr_pkg::SEL_STATIC_BASE: unbanked = static_base;
            cbr_pkg::SEL_STACK:       unbanked = stack_pointer;
            cbr_pkg::SEL_USER_STACK:  unbanked = user_stack_pointer;
            cbr_pkg::SEL_INTR_STACK:  unbanked = interrupt_stack_pointer;
            cbr_pkg::SEL_FLAGS:       unbanked = flags_reg;
            default:                  unbanked = cbr_pkg::WORD_RST;
        endcase
    endfunction

    assign a_banked = is_banked(a_sel_q);
    assign b_banked = is_banked(b_sel_q);
    assign rd_data_a = a_pair ? {bank_rd_b, bank_rd_a}
                     : {cbr_pkg::WORD_RST, (a_banked ? bank_rd_a : side_a)};
    assign rd_data_b = (b_banked && !a_pair) ? bank_rd_b : side_b;
    assign flags_word = flags_reg;
    assign bank_active = bank_sel;
    assign user_stack_active = stack_sel;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_int_clears_flag;
        @(posedge ref_clk) disable iff (rst)
        int_entry |=> !flags_word[cbr_pkg::FLAG_STACK_BIT];
    endproperty
    a_int_clears_flag: assert property (p_int_clears_flag)
        else $error("stack flag not cleared on interrupt entry");

    property p_stack_mux;
        @(posedge ref_clk) disable iff (rst)
        int_entry |=> !user_stack_active && stack_pointer == interrupt_stack_pointer;
    endproperty
    a_stack_mux: assert property (p_stack_mux)
        else $error("wrong stack pointer active");

    property p_bank_hold;
        @(posedge ref_clk) disable iff (rst)
        !(instr_end || int_entry) |=> $stable(bank_active) && $stable(user_stack_active);
    endproperty
    a_bank_hold: assert property (p_bank_hold)
        else $error("selection changed inside an instruction");

    property p_bank_follow;
        @(posedge ref_clk) disable iff (rst)
        instr_end |=> bank_active == $past(flags_word[cbr_pkg::FLAG_BANK_BIT]);
    endproperty
    a_bank_follow: assert property (p_bank_follow)
        else $error("bank select did not follow flag word");

    property p_pc_load;
        @(posedge ref_clk) disable iff (rst)
        pc_wr.en |=> program_counter == $past(pc_wr.data);
    endproperty
    a_pc_load: assert property (p_pc_load)
        else $error("program counter not loaded");

    property p_vtb_load;
        @(posedge ref_clk) disable iff (rst)
        vtb_wr.en |=> vector_table_base == $past(vtb_wr.data);
    endproperty
    a_vtb_load: assert property (p_vtb_load)
        else $error("vector table base not loaded");

    property p_sb_load;
        @(posedge ref_clk) disable iff (rst)
        wr_req.en && wr_req.sel == cbr_pkg::SEL_STATIC_BASE
        |=> static_base == $past(wr_req.data[cbr_pkg::WORD_W-1:0]);
    endproperty
    a_sb_load: assert property (p_sb_load)
        else $error("static base not loaded");

    property p_other_stack_kept;
        @(posedge ref_clk) disable iff (rst)
        wr_req.en && wr_req.sel == cbr_pkg::SEL_STACK && user_stack_active
        |=> $stable(interrupt_stack_pointer);
    endproperty
    a_other_stack_kept: assert property (p_other_stack_kept)
        else $error("inactive stack pointer disturbed");

endmodule // cbr_register_file

// File: testbench/cbr_seq_model.sv
// Sequencer model: ends an instruction one cycle after the bench asks for it
module cbr_seq_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Request from the bench
    input wire logic step,
    // Instruction boundary toward the register file
    output logic instr_end
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Boundary pulse
    // ----------------------------------------
    // Copy of step one cycle later, as long as step; a one-cycle step gives a one-cycle pulse
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            instr_end <= 1'h0;
        end else begin
            instr_end <= step;
        end
    end
endmodule // cbr_seq_model

// File: testbench/cbr_register_file_bench.sv
// Self-checking bench for the banked CPU register file
module cbr_register_file_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'h0, rst = 1'h1, step = 1'h0, instr_end, hw_int_ack = 1'h0;
    logic sw_int_exec = 1'h0, rd_pair_a = 1'h0, bank_active, user_stack_active;
    logic [5:0] sw_int_num = 6'h00;
    cbr_pkg::cbr_wr_t wr_req = '0;
    cbr_pkg::cbr_wide_wr_t pc_wr = '0, vtb_wr = '0;
    cbr_pkg::cbr_sel_t rd_sel_a = cbr_pkg::SEL_DATA_ZERO, rd_sel_b = cbr_pkg::SEL_DATA_ZERO;
    logic [31:0] rd_data_a;
    logic [15:0] rd_data_b, frame_base, static_base, stack_pointer, flags_word;
    logic [19:0] program_counter, vector_table_base;
    int n_fail = 0, checked = 0;
    // Clock at 200 MHz
    always #2.5 ref_clk = ~ref_clk;
    cbr_seq_model seq_u (.ref_clk(ref_clk), .rst(rst), .step(step), .instr_end(instr_end));
    cbr_register_file dut_u (.ref_clk(ref_clk), .rst(rst), .instr_end(instr_end),
        .hw_int_ack(hw_int_ack), .sw_int_exec(sw_int_exec), .sw_int_num(sw_int_num),
        .wr_req(wr_req), .pc_wr(pc_wr), .vtb_wr(vtb_wr), .rd_sel_a(rd_sel_a),
        .rd_sel_b(rd_sel_b), .rd_pair_a(rd_pair_a), .rd_data_a(rd_data_a),
        .rd_data_b(rd_data_b), .frame_base(frame_base), .static_base(static_base),
        .stack_pointer(stack_pointer), .program_counter(program_counter),
        .vector_table_base(vector_table_base), .flags_word(flags_word),
        .bank_active(bank_active), .user_stack_active(user_stack_active));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // One register write, taken at the second edge
    task automatic wr(input cbr_pkg::cbr_sel_t s, input cbr_pkg::cbr_size_t z,
                      input logic [31:0] d);
        @(posedge ref_clk) wr_req <= '{1'h1, s, z, d};
        @(posedge ref_clk) wr_req.en <= 1'h0;
        #1;
    endtask
    // Select both read ports, then wait for the registered data
    task automatic rd(input cbr_pkg::cbr_sel_t a, input cbr_pkg::cbr_sel_t b, input logic p);
        @(posedge ref_clk);
        rd_sel_a <= a;
        rd_sel_b <= b;
        rd_pair_a <= p;
        @(posedge ref_clk);
        #1;
    endtask
    // Sequencer closes the current instruction
    task automatic end_instr();
        @(posedge ref_clk) step <= 1'h1;
        @(posedge ref_clk) step <= 1'h0;
        @(posedge ref_clk);
        #1;
    endtask
    // Hardware or software interrupt entry
    task automatic irq(input logic hw, input logic [5:0] n);
        @(posedge ref_clk);
        hw_int_ack <= hw;
        sw_int_exec <= !hw;
        sw_int_num <= n;
        @(posedge ref_clk);
        hw_int_ack <= 1'h0;
        sw_int_exec <= 1'h0;
        #1;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_words();
        for (int i = 0; i < 6; i++) begin
            wr(cbr_pkg::cbr_sel_t'(i[3:0]), cbr_pkg::SIZE_WORD, 32'h00001000 + i * 32'h0111);
            rd(cbr_pkg::cbr_sel_t'(i[3:0]), cbr_pkg::cbr_sel_t'(i[3:0]), 1'h0);
            chk(rd_data_a, 32'h00001000 + i * 32'h0111);
            chk({16'h0000, rd_data_b}, 32'h00001000 + i * 32'h0111);
        end
    endtask
    task automatic t_bytes();
        for (int i = 0; i < 2; i++) begin
            wr(cbr_pkg::cbr_sel_t'(i[3:0]), cbr_pkg::SIZE_WORD, 32'h00001234);
            wr(cbr_pkg::cbr_sel_t'(i[3:0]), cbr_pkg::SIZE_LOW, 32'h0000ABAB);
            rd(cbr_pkg::cbr_sel_t'(i[3:0]), cbr_pkg::SEL_STATIC_BASE, 1'h0);
            chk(rd_data_a, 32'h000012AB);
            wr(cbr_pkg::cbr_sel_t'(i[3:0]), cbr_pkg::SIZE_HIGH, 32'h0000CDCD);
            rd(cbr_pkg::cbr_sel_t'(i[3:0]), cbr_pkg::SEL_STATIC_BASE, 1'h0);
            chk(rd_data_a, 32'h0000CDAB);
        end
    endtask
    task automatic t_pairs();
        wr(cbr_pkg::SEL_DATA_ZERO, cbr_pkg::SIZE_PAIR, 32'hAABB1122);
        wr(cbr_pkg::SEL_DATA_ONE, cbr_pkg::SIZE_PAIR, 32'hCAFE0001);
        wr(cbr_pkg::SEL_ADDR_ZERO, cbr_pkg::SIZE_PAIR, 32'h12345678);
        rd(cbr_pkg::SEL_DATA_ZERO, cbr_pkg::SEL_STATIC_BASE, 1'h1);
        chk(rd_data_a, 32'hAABB1122);
        rd(cbr_pkg::SEL_DATA_ONE, cbr_pkg::SEL_STATIC_BASE, 1'h1);
        chk(rd_data_a, 32'hCAFE0001);
        rd(cbr_pkg::SEL_DATA_TWO, cbr_pkg::SEL_DATA_THREE, 1'h0);
        chk(rd_data_a, 32'h0000AABB);
        chk({16'h0000, rd_data_b}, 32'h0000CAFE);
        rd(cbr_pkg::SEL_ADDR_ZERO, cbr_pkg::SEL_STATIC_BASE, 1'h1);
        chk(rd_data_a, 32'h12345678);
        rd(cbr_pkg::SEL_ADDR_ONE, cbr_pkg::SEL_ADDR_ONE, 1'h0);
        chk({16'h0000, rd_data_b}, 32'h00001234);
    endtask
    task automatic t_wide();
        @(posedge ref_clk);
        pc_wr <= '{1'h1, 20'hFFFFF};
        vtb_wr <= '{1'h1, 20'hABCDE};
        @(posedge ref_clk);
        pc_wr.en <= 1'h0;
        vtb_wr.en <= 1'h0;
        #1;
        chk(program_counter, 32'h000FFFFF);
        chk(vector_table_base, 32'h000ABCDE);
        wr(cbr_pkg::SEL_STATIC_BASE, cbr_pkg::SIZE_WORD, 32'h0000BEEF);
        chk(static_base, 32'h0000BEEF);
    endtask
    task automatic t_banks();
        wr(cbr_pkg::SEL_DATA_ZERO, cbr_pkg::SIZE_WORD, 32'h00001111);
        wr(cbr_pkg::SEL_FRAME_BASE, cbr_pkg::SIZE_WORD, 32'h00000F0F);
        chk(frame_base, 32'h00000F0F);
        wr(cbr_pkg::SEL_FLAGS, cbr_pkg::SIZE_WORD, 32'h00000010);
        chk(bank_active, 1'h0);
        end_instr();
        chk(bank_active, 1'h1);
        chk(frame_base, 32'h00000000);
        rd(cbr_pkg::SEL_DATA_ZERO, cbr_pkg::SEL_DATA_ZERO, 1'h0);
        chk(rd_data_a, 32'h00000000);
        wr(cbr_pkg::SEL_DATA_ZERO, cbr_pkg::SIZE_WORD, 32'h00002222);
        wr(cbr_pkg::SEL_FLAGS, cbr_pkg::SIZE_WORD, 32'h00000000);
        end_instr();
        chk(bank_active, 1'h0);
        rd(cbr_pkg::SEL_DATA_ZERO, cbr_pkg::SEL_DATA_ZERO, 1'h0);
        chk(rd_data_a, 32'h00001111);
        chk(frame_base, 32'h00000F0F);
    endtask
    task automatic t_stacks();
        logic [5:0] nums [4] = '{6'h00, 6'h1F, 6'h20, 6'h3F};
        wr(cbr_pkg::SEL_USER_STACK, cbr_pkg::SIZE_WORD, 32'h00005555);
        wr(cbr_pkg::SEL_INTR_STACK, cbr_pkg::SIZE_WORD, 32'h0000AAAA);
        chk(stack_pointer, 32'h0000AAAA);
        for (int i = 0; i < 5; i++) begin
            wr(cbr_pkg::SEL_FLAGS, cbr_pkg::SIZE_WORD, 32'h00000080);
            end_instr();
            chk(user_stack_active, 1'h1);
            chk(stack_pointer, 32'h00005555);
            irq(i == 4, (i == 4) ? 6'h00 : nums[i]);
            chk(flags_word[7], (i < 4 && nums[i] > 6'h1F));
            chk(user_stack_active, (i < 4 && nums[i] > 6'h1F));
        end
        wr(cbr_pkg::SEL_STACK, cbr_pkg::SIZE_WORD, 32'h00007777);
        chk(stack_pointer, 32'h00007777);
        wr(cbr_pkg::SEL_FLAGS, cbr_pkg::SIZE_WORD, 32'h00000080);
        end_instr();
        wr(cbr_pkg::SEL_STACK, cbr_pkg::SIZE_WORD, 32'h00006666);
        chk(stack_pointer, 32'h00006666);
        irq(1'h1, 6'h00);
        chk(stack_pointer, 32'h00007777);
    endtask
    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'h0;
        #1;
        chk({flags_word, stack_pointer}, 32'h00000000);
        chk({30'h00000000, bank_active, user_stack_active}, 32'h00000000);
        t_words();
        t_bytes();
        t_pairs();
        t_wide();
        t_banks();
        t_stacks();
        final_report();
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        n_fail++;
        final_report();
    end
endmodule // cbr_register_file_bench
